// File: src/plm_consts.vh
// constants for the palette lookup pixel mapper: register offsets, field positions,
// reset values and encodings
// assumes inclusion by bare name from the design files of the mapper
// ****************************************************************************
// ****************************************************************************
`ifndef PLM_CONSTS_VH
`define PLM_CONSTS_VH

// register byte addresses
`define PLM_ADDR_CFG 12'h000
`define PLM_ADDR_MODE 12'h004
`define PLM_ADDR_INDEX 12'h008
`define PLM_ADDR_DATA 12'h00C
`define PLM_ADDR_STAT 12'h010

// configuration register fields
`define PLM_CFG_DEPTH_LSB 0
`define PLM_CFG_COLOR_BIT 2
`define PLM_CFG_DITHER_BIT 3
`define PLM_CFG_PASSIVE_BIT 4
`define PLM_CFG_RESET 5'h00

// colour depth encodings
`define PLM_DEPTH_4 2'h0
`define PLM_DEPTH_8 2'h1
`define PLM_DEPTH_15 2'h2
`define PLM_DEPTH_16 2'h3

// table mode encodings
`define PLM_MODE_BOTH_RD_LCD 2'h0
`define PLM_MODE_LCD_ONLY 2'h1
`define PLM_MODE_CRT_ONLY 2'h2
`define PLM_MODE_BOTH_RD_CRT 2'h3
`define PLM_MODE_RESET 2'h0

// component banks and data field
`define PLM_BANK_RED 2'h0
`define PLM_BANK_GREEN 2'h1
`define PLM_BANK_BLUE 2'h2
`define PLM_DATA_MSB 7
`define PLM_DATA_LSB 4

`endif

// File: src/plm_table.v
// one 256-entry palette table of 4-bit red, green and blue components
// assumes a single clock; one component write port, two combinational read ports
`timescale 1ns/10ps

module plm_table #(
   parameter ENTRIES = 256,
   parameter IDX_W = 8
) (
   clk,
   ce,
   wr_en,
   wr_idx,
   wr_bank,
   wr_data,
   pix_idx,
   pix_rgb,
   cpu_idx,
   cpu_rgb
);
   `include "plm_consts.vh"
   input wire clk;
   input wire ce;
   input wire wr_en;
   input wire [IDX_W-1:0] wr_idx;
   input wire [1:0] wr_bank;
   input wire [3:0] wr_data;
   input wire [IDX_W-1:0] pix_idx;
   output wire [11:0] pix_rgb;
   input wire [IDX_W-1:0] cpu_idx;
   output wire [11:0] cpu_rgb;

   // entry layout: red 11:8, green 7:4, blue 3:0
   reg [11:0] mem [0:ENTRIES-1];

   // ****************************************************************
   // component write
   // ****************************************************************
   // only the addressed component changes
   always @(posedge clk) begin
      if (ce && wr_en) begin
         case (wr_bank)
            `PLM_BANK_RED: mem[wr_idx][11:8] <= wr_data;
            `PLM_BANK_GREEN: mem[wr_idx][7:4] <= wr_data;
            default: mem[wr_idx][3:0] <= wr_data;
         endcase
      end
   end

   // entry N for index N
   assign pix_rgb = mem[pix_idx];
   assign cpu_rgb = mem[cpu_idx];
endmodule // plm_table

// File: src/plm_top.v
// palette lookup pixel mapper: APB register slave, two palette tables, pixel mapping
// assumes pixel source and APB master on clk; outputs feed panel and CRT/TV pipes
`timescale 1ns/10ps

module plm_top #(
   parameter IDX_W = 8,
   parameter ENTRIES = 256
) (
   clk,
   rst,
   ce,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   pix_valid,
   pix_data,
   pix_ready,
   out_valid,
   lcd_red,
   lcd_green,
   lcd_blue,
   crt_red,
   crt_green,
   crt_blue
);
   `include "plm_consts.vh"
   input wire clk;
   input wire rst;
   input wire ce;
   input wire psel;
   input wire penable;
   input wire pwrite;
   input wire [11:0] paddr;
   input wire [31:0] pwdata;
   output wire [31:0] prdata;
   output wire pready;
   output wire pslverr;
   input wire pix_valid;
   input wire [15:0] pix_data;
   output wire pix_ready;
   output wire out_valid;
   output wire [5:0] lcd_red;
   output wire [5:0] lcd_green;
   output wire [5:0] lcd_blue;
   output wire [5:0] crt_red;
   output wire [5:0] crt_green;
   output wire [5:0] crt_blue;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // linear 4-bit code to 6-bit level, code 0Fh near full scale
   function [5:0] expand4;
      input [3:0] v;
      begin
         expand4 = {v, 2'b00};
      end
   endfunction

   // keep the four most significant bits of a 6-bit level
   function [5:0] trunc4;
      input [5:0] v;
      input en;
      begin
         trunc4 = en ? {v[5:2], 2'b00} : v;
      end
   endfunction

   // pick one component of a 12-bit entry
   function [3:0] pick;
      input [11:0] rgb;
      input [1:0] bank;
      begin
         case (bank)
            `PLM_BANK_RED: pick = rgb[11:8];
            `PLM_BANK_GREEN: pick = rgb[7:4];
            default: pick = rgb[3:0];
         endcase
      end
   endfunction

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [4:0] cfg_ff;
   reg [1:0] mode_ff;
   reg [IDX_W-1:0] idx_ff;
   reg [1:0] bank_ff;
   reg [31:0] prdata_ff;
   reg pready_ff;
   reg pslverr_ff;
   reg [31:0] nxt_prdata;
   reg nxt_slverr;
   reg hold_ff;

   wire [1:0] depth = cfg_ff[`PLM_CFG_DEPTH_LSB+1:`PLM_CFG_DEPTH_LSB];
   wire color_sel = cfg_ff[`PLM_CFG_COLOR_BIT];
   wire dither_en = cfg_ff[`PLM_CFG_DITHER_BIT];
   wire passive = cfg_ff[`PLM_CFG_PASSIVE_BIT];

   wire setup_ph = psel && !penable && !pready_ff;
   wire access_ph = psel && penable && pready_ff;
   wire hit_data = (paddr == `PLM_ADDR_DATA);
   wire data_acc = access_ph && hit_data && !pslverr_ff;
   wire data_wr = data_acc && pwrite;

   // table write enables by mode
   wire wr_lcd = data_wr && (mode_ff != `PLM_MODE_CRT_ONLY);
   wire wr_crt = data_wr && (mode_ff != `PLM_MODE_LCD_ONLY);
   // reads come from CRT table only in the two CRT read modes
   wire rd_crt = mode_ff[1];

   wire [11:0] lcd_cpu_rgb;
   wire [11:0] crt_cpu_rgb;
   wire [11:0] lcd_pix_rgb;
   wire [11:0] crt_pix_rgb;
   wire [3:0] cpu_comp = pick(rd_crt ? crt_cpu_rgb : lcd_cpu_rgb, bank_ff);

   // ****************************************************************
   // read decode
   // ****************************************************************
   // value and error flag presented in the access phase
   always @* begin
      nxt_prdata = 32'h00000000;
      nxt_slverr = 1'b0;
      case (paddr)
         `PLM_ADDR_CFG: nxt_prdata[4:0] = cfg_ff;
         `PLM_ADDR_MODE: nxt_prdata[1:0] = mode_ff;
         `PLM_ADDR_INDEX: nxt_prdata[IDX_W-1:0] = idx_ff;
         `PLM_ADDR_DATA: nxt_prdata[`PLM_DATA_MSB:`PLM_DATA_LSB] = cpu_comp;
         `PLM_ADDR_STAT: nxt_prdata[2:0] = {hold_ff, bank_ff};
         default: nxt_slverr = 1'b1;
      endcase
   end

   // ****************************************************************
   // APB slave: one access cycle, answer from flops
   // ****************************************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h00000000;
      end else if (ce) begin
         if (setup_ph) begin
            pready_ff <= 1'b1;
            pslverr_ff <= nxt_slverr;
            prdata_ff <= pwrite ? 32'h00000000 : nxt_prdata;
         end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
         end
      end
   end

   // register writes and component stepping
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= `PLM_CFG_RESET;
         mode_ff <= `PLM_MODE_RESET;
         idx_ff <= {IDX_W{1'b0}};
         bank_ff <= `PLM_BANK_RED;
      end else if (ce && access_ph && !pslverr_ff) begin
         if (pwrite && paddr == `PLM_ADDR_CFG)
            cfg_ff <= pwdata[4:0];
         if (pwrite && paddr == `PLM_ADDR_MODE)
            mode_ff <= pwdata[1:0];
         if (pwrite && paddr == `PLM_ADDR_INDEX) begin
            idx_ff <= pwdata[IDX_W-1:0];
            bank_ff <= `PLM_BANK_RED;
         end
         if (hit_data) begin
            // red, green, blue, then next entry back at red
            if (bank_ff == `PLM_BANK_BLUE) begin
               bank_ff <= `PLM_BANK_RED;
               idx_ff <= idx_ff + 1'b1;
            end else begin
               bank_ff <= bank_ff + 2'h1;
            end
         end
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

   // ****************************************************************
   // pixel intake: 4 bpp bytes split in two
   // ****************************************************************
   reg [3:0] low_nib_ff;
   reg pix_ready_ff;
   reg issue;
   reg [15:0] cur_pix;

   wire take = pix_valid && pix_ready_ff && !hold_ff;

   // pixel issued this cycle: pending low nibble first, else the new input
   always @* begin
      issue = 1'b0;
      cur_pix = 16'h0000;
      if (hold_ff) begin
         issue = 1'b1;
         cur_pix = {12'h000, low_nib_ff};
      end else if (take) begin
         issue = 1'b1;
         if (depth == `PLM_DEPTH_4)
            cur_pix = {12'h000, pix_data[7:4]};
         else
            cur_pix = pix_data;
      end
   end

   // ready drops while the low nibble is still owed
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_ff <= 1'b0;
         low_nib_ff <= 4'h0;
         pix_ready_ff <= 1'b0;
      end else if (ce) begin
         if (hold_ff) begin
            hold_ff <= 1'b0;
            pix_ready_ff <= 1'b1;
         end else if (take && depth == `PLM_DEPTH_4) begin
            hold_ff <= 1'b1;
            low_nib_ff <= pix_data[3:0];
            pix_ready_ff <= 1'b0;
         end else begin
            pix_ready_ff <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // index selection and tables
   // ****************************************************************
   // 4 bpp index limited to 0-15, 8 bpp full byte
   wire [IDX_W-1:0] pix_idx = (depth == `PLM_DEPTH_4) ?
      {{(IDX_W-4){1'b0}}, cur_pix[3:0]} : cur_pix[IDX_W-1:0];

   // separate LCD and CRT/TV tables
   plm_table #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_lcd_table (
      .clk(clk),
      .ce(ce),
      .wr_en(wr_lcd),
      .wr_idx(idx_ff),
      .wr_bank(bank_ff),
      .wr_data(pwdata[`PLM_DATA_MSB:`PLM_DATA_LSB]),
      .pix_idx(pix_idx),
      .pix_rgb(lcd_pix_rgb),
      .cpu_idx(idx_ff),
      .cpu_rgb(lcd_cpu_rgb)
   );

   plm_table #(.ENTRIES(ENTRIES), .IDX_W(IDX_W)) u_crt_table (
      .clk(clk),
      .ce(ce),
      .wr_en(wr_crt),
      .wr_idx(idx_ff),
      .wr_bank(bank_ff),
      .wr_data(pwdata[`PLM_DATA_MSB:`PLM_DATA_LSB]),
      .pix_idx(pix_idx),
      .pix_rgb(crt_pix_rgb),
      .cpu_idx(idx_ff),
      .cpu_rgb(crt_cpu_rgb)
   );

   // ****************************************************************
   // output mapping
   // ****************************************************************
   reg [5:0] nxt_lr;
   reg [5:0] nxt_lg;
   reg [5:0] nxt_lb;
   reg [5:0] nxt_cr;
   reg [5:0] nxt_cg;
   reg [5:0] nxt_cb;
   reg [5:0] gray;

   // passive panel without dithering keeps four bits per channel
   wire cut = passive && !dither_en;
   wire is16 = (depth == `PLM_DEPTH_16);

   // direct 5:5:5 or 5:6:5 fields, table bypassed
   wire [5:0] d_r = is16 ? {cur_pix[15:11], 1'b0} : {cur_pix[14:10], 1'b0};
   wire [5:0] d_g = is16 ? cur_pix[10:5] : {cur_pix[9:5], 1'b0};
   wire [5:0] d_b = {cur_pix[4:0], 1'b0};

   // panel and tube levels of the pixel issued this cycle
   always @* begin
      if (depth == `PLM_DEPTH_15 || depth == `PLM_DEPTH_16) begin
         // gray from green bits, 16 levels when undithered
         gray = trunc4(d_g, !dither_en);
         nxt_lr = color_sel ? trunc4(d_r, cut) : gray;
         nxt_lg = color_sel ? trunc4(d_g, cut) : gray;
         nxt_lb = color_sel ? trunc4(d_b, cut) : gray;
         nxt_cr = d_r;
         nxt_cg = d_g;
         nxt_cb = d_b;
      end else begin
         // table lookups; panel gray from green only
         gray = expand4(lcd_pix_rgb[7:4]);
         nxt_lr = color_sel ? expand4(lcd_pix_rgb[11:8]) : gray;
         nxt_lg = color_sel ? expand4(lcd_pix_rgb[7:4]) : gray;
         nxt_lb = color_sel ? expand4(lcd_pix_rgb[3:0]) : gray;
         nxt_cr = expand4(crt_pix_rgb[11:8]);
         nxt_cg = expand4(crt_pix_rgb[7:4]);
         nxt_cb = expand4(crt_pix_rgb[3:0]);
      end
   end

   // ****************************************************************
   // output registers
   // ****************************************************************
   reg out_valid_ff;
   reg [5:0] lcd_r_ff;
   reg [5:0] lcd_g_ff;
   reg [5:0] lcd_b_ff;
   reg [5:0] crt_r_ff;
   reg [5:0] crt_g_ff;
   reg [5:0] crt_b_ff;

   // one pixel per issue, held when nothing is issued
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_valid_ff <= 1'b0;
         lcd_r_ff <= 6'h00;
         lcd_g_ff <= 6'h00;
         lcd_b_ff <= 6'h00;
         crt_r_ff <= 6'h00;
         crt_g_ff <= 6'h00;
         crt_b_ff <= 6'h00;
      end else if (ce) begin
         out_valid_ff <= issue;
         if (issue) begin
            lcd_r_ff <= nxt_lr;
            lcd_g_ff <= nxt_lg;
            lcd_b_ff <= nxt_lb;
            crt_r_ff <= nxt_cr;
            crt_g_ff <= nxt_cg;
            crt_b_ff <= nxt_cb;
         end
      end
   end

   assign pix_ready = pix_ready_ff;
   assign out_valid = out_valid_ff;
   assign lcd_red = lcd_r_ff;
   assign lcd_green = lcd_g_ff;
   assign lcd_blue = lcd_b_ff;
   assign crt_red = crt_r_ff;
   assign crt_green = crt_g_ff;
   assign crt_blue = crt_b_ff;
endmodule // plm_top

// File: dv/plm_top_props.sv
// checker for the palette mapper ports: bus answer, pixel pacing, level mapping
// assumes one clock with async high reset; bound to plm_top below
`timescale 1ns/10ps
`include "plm_consts.vh"
module plm_checker (
   input wire clk,
   input wire rst,
   input wire ce,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire pix_valid,
   input wire [15:0] pix_data,
   input wire pix_ready,
   input wire out_valid,
   input wire [5:0] lcd_red,
   input wire [5:0] lcd_green,
   input wire [5:0] lcd_blue,
   input wire [5:0] crt_red,
   input wire [5:0] crt_green,
   input wire [5:0] crt_blue
);
   // ****************************************
   // shadow of configuration and last pixel
   // ****************************************
   reg [4:0] cfg_ff;
   reg [15:0] pix_ff;
   wire take = pix_valid && pix_ready && ce;
   wire [1:0] dep = cfg_ff[1:0];
   // follow configuration writes; keep the pixel taken last
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff <= `PLM_CFG_RESET;
         pix_ff <= 16'h0000;
      end else begin
         if (ce && psel && penable && pready && pwrite && paddr == `PLM_ADDR_CFG)
            cfg_ff <= pwdata[4:0];
         if (take)
            pix_ff <= pix_data;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_answer_next: assert property (psel && !penable && ce ##1 ce |-> pready)
      else $error("bus answer missing after setup");
   a_answer_once: assert property (pready && ce |=> !pready)
      else $error("bus answer stood too long");
   a_unmapped_err: assert property (pready && paddr > `PLM_ADDR_STAT
      |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
   a_pixel_answer: assert property (take |=> out_valid)
      else $error("no output pixel after take");
   a_nibble_pair: assert property (take && dep == `PLM_DEPTH_4
      |=> out_valid && !pix_ready ##1 out_valid && pix_ready) else $error("nibble pair broken");
   a_wide_stream: assert property (take && dep != `PLM_DEPTH_4 |=> pix_ready)
      else $error("wide depth stalled");
   a_mono_gray: assert property (out_valid && !cfg_ff[2]
      |-> lcd_red == lcd_green && lcd_blue == lcd_green) else $error("mono panel not gray");
   a_direct_crt: assert property (out_valid && dep == `PLM_DEPTH_16
      |-> {crt_red, crt_green, crt_blue} == {pix_ff[15:11], 1'h0, pix_ff[10:5], pix_ff[4:0], 1'h0})
      else $error("direct colour not passed");
   a_gray_fine: assert property (out_valid && dep == `PLM_DEPTH_16 && cfg_ff[3:2] == 2'h2
      |-> lcd_green == pix_ff[10:5]) else $error("six bit gray lost");
   a_gray_coarse: assert property (out_valid && dep == `PLM_DEPTH_15 && cfg_ff[3:2] == 2'h0
      |-> lcd_green == {pix_ff[9:6], 2'h0}) else $error("undithered gray not cut");
endmodule // plm_checker
bind plm_top plm_checker plm_checker_inst (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .pix_valid, .pix_data, .pix_ready, .out_valid,
   .lcd_red, .lcd_green, .lcd_blue, .crt_red, .crt_green, .crt_blue);

// File: dv/plm_sink.sv
// far-side model: panel and tube pipes that log every mapped pixel
// assumes one pixel per cycle while out_valid is high; no back-pressure exists
`timescale 1ns/10ps
module plm_sink (
   input wire clk,
   input wire out_valid,
   input wire [5:0] lcd_red,
   input wire [5:0] lcd_green,
   input wire [5:0] lcd_blue,
   input wire [5:0] crt_red,
   input wire [5:0] crt_green,
   input wire [5:0] crt_blue
);
   reg [35:0] cap [0:255];
   integer n = 0;
   // log panel levels then tube levels for each pixel
   always @(posedge clk) begin
      if (out_valid) begin
         cap[n % 256] <= {lcd_red, lcd_green, lcd_blue, crt_red, crt_green, crt_blue};
         n <= n + 1;
      end
   end
endmodule // plm_sink

// File: dv/plm_top_tb.sv
// testbench for the palette mapper: table loading, readback, refusals, pixel rows
// assumes plm_top, plm_sink and the bound checker are compiled ahead of it
`timescale 1ns/10ps
`include "plm_consts.vh"
module plm_top_tb;
   // ****************************************
   // rows and signals
   // ****************************************
   localparam [59:0] ROWS = {5'h03, 5'h0B, 5'h17, 5'h1F, 5'h02, 5'h0A, 5'h16, 5'h06, 5'h01,
      5'h05, 5'h08, 5'h04};
   localparam [127:0] PIX = {16'h7BDE, 16'h1234, 16'h8421, 16'hFFFF, 16'h0077, 16'h5A0F,
      16'h00A5, 16'hFF01};
   reg clk = 1'h0, rst = 1'h1, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   reg pix_valid = 1'h0, e;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h0, q;
   reg [15:0] pix_data = 16'h0000, p;
   reg [1:0] mode;
   reg [4:0] c;
   reg [11:0] x;
   reg [11:0] tl [0:255];
   reg [11:0] tc [0:255];
   integer bad_count = 0, checks_done = 0, i, j, m, base;
   wire [31:0] prdata;
   wire pready, pslverr, pix_ready, out_valid;
   wire [5:0] lcd_red, lcd_green, lcd_blue, crt_red, crt_green, crt_blue;
   plm_top plm_top_inst (.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .pix_valid, .pix_data, .pix_ready, .out_valid, .lcd_red, .lcd_green,
      .lcd_blue, .crt_red, .crt_green, .crt_blue);
   plm_sink plm_sink_inst (.clk, .out_valid, .lcd_red, .lcd_green, .lcd_blue, .crt_red,
      .crt_green, .crt_blue);
   // 10 MHz clock
   always #50 clk = ~clk;
   // ****************************************
   // helpers
   // ****************************************
   task chk(input string s, input [35:0] ex, input [35:0] got);
      begin
         checks_done = checks_done + 1;
         if (got !== ex) begin
            bad_count = bad_count + 1;
            $display("unexpected %s expected %h seen %h", s, ex, got);
         end
      end
   endtask
   task print_verdict;
      begin
         if (bad_count == 0 && checks_done > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   // one bus transfer, held until pready, then an idle cycle
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'h1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'h1;
         @(posedge clk);
         while (pready !== 1'h1) @(posedge clk);
         q = prdata;
         e = pslverr;
         psel <= 1'h0;
         penable <= 1'h0;
         @(posedge clk);
      end
   endtask
   // offer one pixel word, valid kept high for streaming
   task send(input [15:0] d);
      begin
         pix_data <= d;
         pix_valid <= 1'h1;
         @(posedge clk);
         while (pix_ready !== 1'h1) @(posedge clk);
      end
   endtask
   function [3:0] code(input [7:0] n, input [1:0] b);
      code = (n == 8'h77) ? 4'hC : n[3:0] + 4'h5 * b + (b == 2'h1 ? 4'h0 : 4'h3 * n[7:4]);
   endfunction
   task ld(input [7:0] n, input [3:0] f);
      integer b;
      begin
         apb(1'h1, `PLM_ADDR_INDEX, {24'h0, n});
         for (b = 0; b < 3; b = b + 1)
            apb(1'h1, `PLM_ADDR_DATA, {24'h0, code(n, b[1:0]) ^ f, 4'h0});
         x = {code(n, 2'h0), code(n, 2'h1), code(n, 2'h2)} ^ {3{f}};
         if (mode != `PLM_MODE_CRT_ONLY) tl[n] = x;
         if (mode != `PLM_MODE_LCD_ONLY) tc[n] = x;
      end
   endtask
   function [17:0] lvl(input [11:0] t);
      lvl = {t[11:8], 2'h0, t[7:4], 2'h0, t[3:0], 2'h0};
   endfunction
   // expected panel and tube levels of one pixel
   function [35:0] expx(input [4:0] k, input [7:0] n, input [15:0] d);
      reg [17:0] l, r;
      begin
         if (k[1:0] == `PLM_DEPTH_15) r = {d[14:10], 1'h0, d[9:5], 1'h0, d[4:0], 1'h0};
         else if (k[1:0] == `PLM_DEPTH_16) r = {d[15:11], 1'h0, d[10:5], d[4:0], 1'h0};
         else r = lvl(tc[n]);
         l = k[1] ? r : lvl(tl[n]);
         if (!k[2]) l = {3{l[11:6]}};
         if (!k[3] && (!k[2] || k[4])) l = l & {3{6'h3C}};
         expx = {l, r};
      end
   endfunction
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      chk("reset levels", 36'h0, {pix_ready, out_valid, lcd_green, crt_red, crt_blue});
      rst <= 1'h0;
      @(posedge clk);
      @(negedge clk);
      chk("ready after reset", 36'h1, pix_ready);
      @(posedge clk);
      mode = `PLM_MODE_BOTH_RD_LCD;
      apb(1'h1, `PLM_ADDR_MODE, 32'h0);
      for (i = 0; i < 16; i = i + 1) ld(i[7:0], 4'h0);
      ld(8'h77, 4'h0);
      ld(8'hA5, 4'h0);
      for (m = 1; m < 3; m = m + 1) begin
         mode = m[1:0];
         apb(1'h1, `PLM_ADDR_MODE, m);
         ld(m[7:0] + 8'h0D, 4'hF);
      end
      // entries 0E and 0F read back from each table
      for (m = 0; m < 4; m = m + 3) begin
         apb(1'h1, `PLM_ADDR_MODE, m);
         apb(1'h1, `PLM_ADDR_INDEX, 32'h0E);
         apb(1'h0, `PLM_ADDR_DATA, 32'h0);
         if (m == 0) apb(1'h1, 12'h80C, 32'hFFFFFFFF);
         if (m == 0) chk("unmapped write", 36'h1, e);
         apb(1'h1, `PLM_ADDR_INDEX, 32'h0E);
         for (j = 0; j < 6; j = j + 1) begin
            apb(1'h0, `PLM_ADDR_DATA, 32'h0);
            x = m ? tc[8'h0E + j / 3] : tl[8'h0E + j / 3];
            chk("table read", {x[11 - 4 * (j % 3) -: 4], 4'h0}, q);
         end
      end
      apb(1'h0, 12'h014, 32'h0);
      chk("unmapped read", 36'h1, {q, e});
      // pixel rows: one configuration, four words streamed back to back
      for (i = 0; i < 12; i = i + 1) begin
         c = ROWS[5 * i +: 5];
         apb(1'h1, `PLM_ADDR_CFG, {27'h0, c});
         base = plm_sink_inst.n;
         for (j = 0; j < 4; j = j + 1) send(PIX[16 * (j + 4 * c[1]) +: 16]);
         pix_valid <= 1'h0;
         repeat (4) @(posedge clk);
         for (j = 0; j < 4; j = j + 1) begin
            p = PIX[16 * (j + 4 * c[1]) +: 16];
            if (c[1:0] == `PLM_DEPTH_4) begin
               chk("upper nibble", expx(c, {4'h0, p[7:4]}, p), plm_sink_inst.cap[base]);
               chk("lower nibble", expx(c, {4'h0, p[3:0]}, p), plm_sink_inst.cap[base + 1]);
               base = base + 2;
            end else begin
               chk("pixel", expx(c, p[7:0], p), plm_sink_inst.cap[base]);
               base = base + 1;
            end
         end
         chk("pixel count", base, plm_sink_inst.n);
      end
      // clock enable low freezes pixel intake
      ce <= 1'h0;
      pix_valid <= 1'h1;
      repeat (4) @(posedge clk);
      chk("frozen count", base, plm_sink_inst.n);
      pix_valid <= 1'h0;
      ce <= 1'h1;
      repeat (2) @(posedge clk);
      // mid-run reset: outputs cleared, ready one edge after release
      rst <= 1'h1;
      @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      chk("reset again", 36'h0, {pix_ready, out_valid, pready, lcd_red, crt_green});
      @(posedge clk);
      chk("ready again", 36'h1, pix_ready);
      apb(1'h0, `PLM_ADDR_CFG, 32'h0);
      chk("config after reset", 36'h0, {e, q});
      print_verdict;
   end
   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge clk);
      bad_count = bad_count + 1;
      print_verdict;
   end
endmodule // plm_top_tb
